// ==== pkg/mrhs_params.svh ====
// offsets, field positions and word indices of the message ram host staging buffers
//
// Behaviour
// (RULE1) write and read paths: host set plus shadow set
// (RULE2) request number write swaps write host and shadow
// (RULE3) swap moves mask and number into shadow fields
// (RULE4) request sets busy; handler copies shadow, then clears
// (RULE5) host may load next message during copy
// (RULE6) request while busy pends; chained at copy end
// (RULE7) host waits for pending clear before next request
// (RULE8) write staging access while pending: blocked, error flag; reads of the request register still pass
// (RULE9) write mask: host bits 0-2, shadow 16-18
// (RULE10) host writes data, header, mask, then number
// (RULE11) fetch trigger copies selects and number internally
// (RULE12) fetch sets read busy, copies buffer, clears busy
// (RULE13) host sets fetch or view only when idle
// (RULE14) view swaps read sets and held number/selects
// (RULE15) host reads fetched set while shadow refills
// (RULE16) pipelined read sequence; last read view only
// (RULE17) read mask: selects bits 0-1, ready 16-17
// (RULE18) completed fetch shows data, header, status words
// (RULE19) per channel two-half store, one owner each
// (RULE20) only accepted frames move to message ram
// (RULE21) channel store moves whole 32-bit words
// (RULE22) copy end sets or clears transmit pending flag
// (RULE23) every ram word is 32 data plus parity
// (RULE24) fetch of fifo head uses and advances pointer
// (RULE25) one transfer touches the ram per cycle
`ifndef MRHS_PARAMS_SVH
`define MRHS_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define MRHS_WCM_OFS      8'h00
`define MRHS_WRC_OFS      8'h04
`define MRHS_RCM_OFS      8'h08
`define MRHS_RRC_OFS      8'h0c
`define MRHS_ERR_OFS      8'h10
`define MRHS_FCFG_OFS     8'h14
`define MRHS_WHDR_PAGE    4'h2
`define MRHS_RHDR_PAGE    4'h3
`define MRHS_WDAT_PAGE    3'h2
`define MRHS_RDAT_PAGE    3'h3

// ************************************************************
// field positions
// ************************************************************
`define MRHS_LH_BIT       0
`define MRHS_LD_BIT       1
`define MRHS_STX_BIT      2
`define MRHS_RRC_VIEW     8
`define MRHS_RRC_REQ      9
`define MRHS_FCFG_EN      15

// ************************************************************
// message layout in words
// ************************************************************
`define MRHS_STATUS_IDX   4'h3
`define MRHS_DATA_BASE    4'h4
`define MRHS_LAST_IDX     4'hb

`endif

// ==== pkg/mrhs_pkg.sv ====
// types of the message ram host staging buffers
package mrhs_pkg;
    typedef logic [6:0] mrhs_bufnum_t;
    typedef logic [3:0] mrhs_widx_t;
    typedef enum logic [2:0] {
        MRHS_IDLE   = 3'b000,
        MRHS_WCOPY  = 3'b001,
        MRHS_RFETCH = 3'b010,
        MRHS_TSA    = 3'b011,
        MRHS_TSB    = 3'b100
    } mrhs_state_t;
endpackage

// ==== rtl/mrhs_tstore.sv ====
// double-buffered transient store of one channel
`timescale 1ns/1ps
`default_nettype none
module mrhs_tstore import mrhs_pkg::*; (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ch_wr_valid,
    input  wire mrhs_widx_t   ch_wr_idx,
    input  wire logic [31:0]  ch_wr_data,
    input  wire logic         ch_frame_end,
    input  wire logic         ch_accept,
    input  wire mrhs_bufnum_t ch_target,
    input  wire mrhs_widx_t   ch_rd_idx,
    output logic [31:0]       ch_rd_data,
    output logic              ch_busy,
    output logic              hd_pending,
    output mrhs_bufnum_t      hd_num,
    input  wire mrhs_widx_t   hd_idx,
    output logic [31:0]       hd_word,
    input  wire logic         hd_ack
);
    logic [31:0]  mem_q [0:31];
    logic         own_q;
    logic         pend_q;
    mrhs_bufnum_t num_q;
    wire          swap = ch_frame_end & ch_accept & (~pend_q | hd_ack); // RULE20

    // ************************************************************
    // word-wide storage, halves selected by owner bit
    // ************************************************************
    always_ff @(posedge pclk) begin
        if (ch_wr_valid) begin
            mem_q[{own_q, ch_wr_idx}] <= ch_wr_data; // RULE21
        end
        ch_rd_data <= mem_q[{own_q, ch_rd_idx}];
    end

    // a frame ending while the handler still holds its half is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_q  <= 1'b0;
            pend_q <= 1'b0;
            num_q  <= 7'h00;
        end else begin
            if (swap) begin
                own_q  <= ~own_q; // RULE19
                num_q  <= ch_target;
            end
            pend_q <= swap | (pend_q & ~hd_ack);
        end
    end

    assign ch_busy    = pend_q;
    assign hd_pending = pend_q;
    assign hd_num     = num_q;
    assign hd_word    = mem_q[{~own_q, hd_idx}];
endmodule
`default_nettype wire

// ==== rtl/mrhs_top.sv ====
// message ram with host staging sets, channel stores and apb slave
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mrhs_params.svh"
module mrhs_top import mrhs_pkg::*; (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    output logic [127:0]      transmit_pending_flag,
    input  wire logic         cha_wr_valid,
    input  wire mrhs_widx_t   cha_wr_idx,
    input  wire logic [31:0]  cha_wr_data,
    input  wire logic         cha_frame_end,
    input  wire logic         cha_accept,
    input  wire mrhs_bufnum_t cha_target,
    input  wire mrhs_widx_t   cha_rd_idx,
    output logic [31:0]       cha_rd_data,
    output logic              cha_busy,
    input  wire logic         chb_wr_valid,
    input  wire mrhs_widx_t   chb_wr_idx,
    input  wire logic [31:0]  chb_wr_data,
    input  wire logic         chb_frame_end,
    input  wire logic         chb_accept,
    input  wire mrhs_bufnum_t chb_target,
    input  wire mrhs_widx_t   chb_rd_idx,
    output logic [31:0]       chb_rd_data,
    output logic              chb_busy
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic mrhs_widx_t win_idx(input logic [7:0] a);
        win_idx = a[6] ? 4'(`MRHS_DATA_BASE + {1'b0, a[4:2]}) : {2'b00, a[3:2]};
    endfunction

    function automatic logic sec_hit(input mrhs_widx_t i, input logic hdr,
                                     input logic dat, input logic with_status);
        if (i < `MRHS_STATUS_IDX)       sec_hit = hdr;
        else if (i == `MRHS_STATUS_IDX) sec_hit = hdr & with_status;
        else                            sec_hit = dat;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [32:0]  ram_q [0:2047];
    logic [31:0]  wset_q [0:31]; // RULE1
    logic [31:0]  rset_q [0:31];
    mrhs_state_t  state_q;
    mrhs_widx_t   cnt_q;
    logic [2:0]   wcm_host_q;
    logic [2:0]   wcm_sh_q;
    mrhs_bufnum_t wnum_host_q;
    mrhs_bufnum_t wnum_sh_q;
    logic         wbusy_q;
    logic         wpend_q;
    logic         wsel_q;
    logic [1:0]   rcm_sel_q;
    logic [1:0]   held_sel_q;
    logic [1:0]   rhost_sel_q;
    mrhs_bufnum_t rnum_sh_q;
    mrhs_bufnum_t held_num_q;
    mrhs_bufnum_t rhost_num_q;
    mrhs_bufnum_t fetch_num_q;
    mrhs_bufnum_t fptr_q;
    logic         rbusy_q;
    logic         rsel_q;
    logic         err_q;
    logic [15:0]  fcfg_q;
    logic [127:0] txp_q;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire          acc      = psel & penable;
    wire          setup    = psel & ~penable;
    wire          sel_wcm  = paddr == `MRHS_WCM_OFS;
    wire          sel_wrc  = paddr == `MRHS_WRC_OFS;
    wire          sel_rcm  = paddr == `MRHS_RCM_OFS;
    wire          sel_rrc  = paddr == `MRHS_RRC_OFS;
    wire          sel_err  = paddr == `MRHS_ERR_OFS;
    wire          sel_fcfg = paddr == `MRHS_FCFG_OFS;
    wire          in_whdr  = paddr[7:4] == `MRHS_WHDR_PAGE && paddr[3:2] != 2'b11;
    wire          in_rhdr  = paddr[7:4] == `MRHS_RHDR_PAGE;
    wire          in_wdat  = paddr[7:5] == `MRHS_WDAT_PAGE;
    wire          in_rdat  = paddr[7:5] == `MRHS_RDAT_PAGE;
    wire          wstage   = sel_wcm | sel_wrc | in_whdr | in_wdat;
    wire          mapped   = wstage | sel_rcm | sel_rrc | sel_err | sel_fcfg
                             | in_rhdr | in_rdat;
    wire          blocked  = wstage & wpend_q & ~(sel_wrc & ~pwrite); // RULE8
    wire          wr_ok    = acc & pwrite & ~blocked;
    wire          err_set  = acc & blocked; // RULE8
    wire          wcm_wr   = wr_ok & sel_wcm;
    wire          wrc_wr   = wr_ok & sel_wrc;
    wire          wset_wr  = wr_ok & (in_whdr | in_wdat);
    wire          rrc_wr   = wr_ok & sel_rrc & ~rbusy_q;
    wire          view_now = rrc_wr & pwdata[`MRHS_RRC_VIEW];
    wire          req_now  = rrc_wr & pwdata[`MRHS_RRC_REQ];
    wire mrhs_bufnum_t wr_num = pwdata[6:0];
    wire mrhs_widx_t   a_idx  = win_idx(paddr);

    // ************************************************************
    // handler sequencing
    // ************************************************************
    wire          last    = cnt_q == `MRHS_LAST_IDX;
    wire          w_done  = state_q == MRHS_WCOPY && last;
    wire          r_done  = state_q == MRHS_RFETCH && last;
    wire          do_swap = (wrc_wr & (~wbusy_q | w_done)) | (w_done & wpend_q);
    wire          pend_set = wrc_wr & wbusy_q & ~w_done;
    wire          busy_clr = w_done & ~wpend_q & ~wrc_wr;
    wire mrhs_bufnum_t swap_num = wrc_wr ? wr_num : wnum_host_q;
    wire          fifo_hit = fcfg_q[`MRHS_FCFG_EN] && wr_num == fcfg_q[6:0];
    wire          ta_pend;
    wire          tb_pend;
    wire mrhs_bufnum_t ta_num;
    wire mrhs_bufnum_t tb_num;
    wire [31:0]   ta_word;
    wire [31:0]   tb_word;
    wire          ta_ack  = state_q == MRHS_TSA && last;
    wire          tb_ack  = state_q == MRHS_TSB && last;

    // a single address mux keeps every source off the ram but one
    wire [10:0]   ram_addr =
        state_q == MRHS_WCOPY  ? {wnum_sh_q, cnt_q} :
        state_q == MRHS_RFETCH ? {fetch_num_q, cnt_q} :
        state_q == MRHS_TSA    ? {ta_num, cnt_q} : {tb_num, cnt_q}; // RULE25
    wire [31:0]   ram_wdata =
        state_q == MRHS_WCOPY ? wset_q[{~wsel_q, cnt_q}] :
        state_q == MRHS_TSA   ? ta_word : tb_word;
    wire          ram_we =
        (state_q == MRHS_WCOPY
         && sec_hit(cnt_q, wcm_sh_q[`MRHS_LH_BIT], wcm_sh_q[`MRHS_LD_BIT], 1'b0))
        || state_q == MRHS_TSA || state_q == MRHS_TSB;
    wire          fetch_we = state_q == MRHS_RFETCH
        && sec_hit(cnt_q, held_sel_q[`MRHS_LH_BIT], held_sel_q[`MRHS_LD_BIT], 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MRHS_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            case (state_q)
                MRHS_IDLE: begin
                    cnt_q <= 4'h0;
                    if (wbusy_q)      state_q <= MRHS_WCOPY; // RULE4
                    else if (rbusy_q) state_q <= MRHS_RFETCH; // RULE12
                    else if (ta_pend) state_q <= MRHS_TSA; // RULE20
                    else if (tb_pend) state_q <= MRHS_TSB;
                end
                MRHS_WCOPY, MRHS_RFETCH, MRHS_TSA, MRHS_TSB: begin
                    cnt_q <= 4'(cnt_q + 4'h1);
                    if (last) state_q <= MRHS_IDLE;
                end
                default: state_q <= MRHS_IDLE;
            endcase
        end
    end

    // ************************************************************
    // storage arrays
    // ************************************************************
    always_ff @(posedge pclk) begin
        if (ram_we) ram_q[ram_addr] <= {^ram_wdata, ram_wdata}; // RULE23
        if (fetch_we) rset_q[{~rsel_q, cnt_q}] <= ram_q[ram_addr][31:0]; // RULE12 RULE15
        if (wset_wr) wset_q[{wsel_q, a_idx}] <= pwdata; // RULE5
    end

    // ************************************************************
    // write staging control
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcm_host_q  <= 3'h0;
            wcm_sh_q    <= 3'h0;
            wnum_host_q <= 7'h00;
            wnum_sh_q   <= 7'h00;
            wsel_q      <= 1'b0;
        end else begin
            if (wcm_wr) wcm_host_q <= pwdata[2:0]; // RULE9
            if (do_swap) begin
                wsel_q      <= ~wsel_q; // RULE2
                wcm_sh_q    <= wcm_host_q; // RULE3
                wcm_host_q  <= wcm_sh_q;
                wnum_sh_q   <= swap_num;
                wnum_host_q <= wnum_sh_q;
            end else if (pend_set) begin
                wnum_host_q <= wr_num;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wbusy_q <= 1'b0;
            wpend_q <= 1'b0;
            txp_q   <= 128'h0;
            err_q   <= 1'b0;
        end else begin
            wbusy_q <= do_swap | (wbusy_q & ~busy_clr); // RULE4
            wpend_q <= pend_set | (wpend_q & ~w_done); // RULE6
            if (w_done) txp_q[wnum_sh_q] <= wcm_sh_q[`MRHS_STX_BIT]; // RULE22
            err_q   <= err_set | (err_q & ~(wr_ok & sel_err & pwdata[0])); // RULE8
        end
    end

    // ************************************************************
    // read staging control
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsel_q      <= 1'b0;
            rhost_num_q <= 7'h00;
            rhost_sel_q <= 2'h0;
            held_num_q  <= 7'h00;
            held_sel_q  <= 2'h0;
        end else begin
            if (view_now) begin
                rsel_q      <= ~rsel_q; // RULE14
                rhost_num_q <= held_num_q;
                rhost_sel_q <= held_sel_q;
            end
            if (req_now) begin
                held_num_q <= wr_num; // RULE11
                held_sel_q <= rcm_sel_q;
            end else if (view_now) begin
                held_num_q <= rhost_num_q;
                held_sel_q <= rhost_sel_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbusy_q     <= 1'b0;
            rcm_sel_q   <= 2'h0;
            rnum_sh_q   <= 7'h00;
            fetch_num_q <= 7'h00;
            fptr_q      <= 7'h00;
            fcfg_q      <= 16'h0000;
        end else begin
            if (wr_ok & sel_rcm) rcm_sel_q <= pwdata[1:0]; // RULE17
            if (rrc_wr) rnum_sh_q <= wr_num;
            if (wr_ok & sel_fcfg) begin
                fcfg_q <= pwdata[15:0];
                fptr_q <= pwdata[6:0];
            end else if (req_now & fifo_hit) begin
                fptr_q <= fptr_q == fcfg_q[14:8] ? fcfg_q[6:0] : 7'(fptr_q + 7'h01); // RULE24
            end
            if (req_now) fetch_num_q <= fifo_hit ? fptr_q : wr_num; // RULE24
            rbusy_q <= req_now | (rbusy_q & ~r_done); // RULE12
        end
    end

    // ************************************************************
    // read-back
    // ************************************************************
    wire [31:0] wcm_rd = {13'h0, wcm_sh_q, 13'h0, wcm_host_q}; // RULE9
    wire [31:0] wrc_rd = {wbusy_q, 8'h0, wnum_sh_q, wpend_q, 8'h0, wnum_host_q};
    wire [31:0] rcm_rd = {14'h0, rhost_sel_q, 14'h0, rcm_sel_q}; // RULE17
    wire [31:0] rrc_rd = {9'h0, rhost_num_q, rbusy_q, 8'h0, rnum_sh_q};
    wire [31:0] rd_mux =
        blocked           ? 32'h0 :
        sel_wcm           ? wcm_rd :
        sel_wrc           ? wrc_rd :
        sel_rcm           ? rcm_rd :
        sel_rrc           ? rrc_rd :
        sel_err           ? {31'h0, err_q} :
        sel_fcfg          ? {16'h0, fcfg_q} :
        (in_whdr|in_wdat) ? wset_q[{wsel_q, a_idx}] :
        (in_rhdr|in_rdat) ? rset_q[{rsel_q, a_idx}] : 32'h0; // RULE18

    // read data is caught in the setup cycle so the slave never stalls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0 : rd_mux;
            pslverr <= ~mapped;
        end
    end

    assign pready = 1'b1;
    assign transmit_pending_flag = txp_q;

    // ************************************************************
    // channel stores
    // ************************************************************
    mrhs_tstore u_store_a (
        .pclk         (pclk),
        .presetn      (presetn),
        .ch_wr_valid  (cha_wr_valid),
        .ch_wr_idx    (cha_wr_idx),
        .ch_wr_data   (cha_wr_data),
        .ch_frame_end (cha_frame_end),
        .ch_accept    (cha_accept),
        .ch_target    (cha_target),
        .ch_rd_idx    (cha_rd_idx),
        .ch_rd_data   (cha_rd_data),
        .ch_busy      (cha_busy),
        .hd_pending   (ta_pend),
        .hd_num       (ta_num),
        .hd_idx       (cnt_q),
        .hd_word      (ta_word),
        .hd_ack       (ta_ack)
    );
    mrhs_tstore u_store_b (
        .pclk         (pclk),
        .presetn      (presetn),
        .ch_wr_valid  (chb_wr_valid),
        .ch_wr_idx    (chb_wr_idx),
        .ch_wr_data   (chb_wr_data),
        .ch_frame_end (chb_frame_end),
        .ch_accept    (chb_accept),
        .ch_target    (chb_target),
        .ch_rd_idx    (chb_rd_idx),
        .ch_rd_data   (chb_rd_data),
        .ch_busy      (chb_busy),
        .hd_pending   (tb_pend),
        .hd_num       (tb_num),
        .hd_idx       (cnt_q),
        .hd_word      (tb_word),
        .hd_ack       (tb_ack)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_req_idle;
        wrc_wr && !wbusy_q;
    endsequence
    sequence s_fetch_req;
        req_now;
    endsequence

    a_req_swaps_sets: assert property (s_req_idle |=> wbusy_q && wsel_q != $past(wsel_q)) // RULE2
        else $error("request did not swap write sets");
    a_swap_moves_fields: assert property (s_req_idle |=> wnum_sh_q == $past(wr_num)
        && wcm_sh_q == $past(wcm_host_q)) // RULE3
        else $error("shadow number or mask not moved");
    a_copy_end_clears: assert property (w_done && !wpend_q && !wrc_wr |=> !wbusy_q) // RULE4
        else $error("write busy not cleared");
    a_pend_chain_next: assert property (w_done && wpend_q |=> wbusy_q && !wpend_q
        && wsel_q != $past(wsel_q) ##1 state_q == MRHS_WCOPY) // RULE6
        else $error("pending request not chained");
    a_blocked_sets_err: assert property (err_set |=> err_q && $stable(wcm_host_q)) // RULE8
        else $error("blocked access not flagged");
    a_fetch_goes_busy: assert property (s_fetch_req |=> rbusy_q[*2]) // RULE12
        else $error("fetch did not raise read busy");
    a_view_swaps_held: assert property (view_now |=> rsel_q != $past(rsel_q)
        && rhost_num_q == $past(held_num_q)) // RULE14
        else $error("view did not swap read sets");
    a_txpend_follows: assert property (w_done |=> txp_q[$past(wnum_sh_q)]
        == $past(wcm_sh_q[`MRHS_STX_BIT])) // RULE22
        else $error("transmit pending not updated");
    a_ram_parity_ok: assert property (ram_we |=> ram_q[$past(ram_addr)][32]
        == ^ram_q[$past(ram_addr)][31:0]) // RULE23
        else $error("ram word parity wrong");
    a_one_ram_user: assert property (ram_we |-> state_q != MRHS_IDLE
        && state_q != MRHS_RFETCH) // RULE25
        else $error("ram written outside a transfer");
endmodule
`default_nettype wire

// ==== test/mrhs_chan_model.sv ====
// channel controller model streaming one frame into its store half
`timescale 1ns/1ps
`default_nettype none
module mrhs_chan_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       acc,
    input  wire logic [6:0] tgt,
    output logic            wr_valid,
    output logic [3:0]      wr_idx,
    output logic [31:0]     wr_data,
    output logic            frame_end,
    output logic            accept,
    output logic [6:0]      target
);
    // ********************
    // frame sequencer
    // ********************
    logic [4:0]  cnt_q;
    logic [31:0] word;
    assign word      = {8'hc0, 13'h0, tgt, wr_idx};
    assign wr_valid  = (cnt_q != 5'h0) && (cnt_q < 5'hd);
    assign wr_idx    = 4'(cnt_q - 5'h1);
    // idle data is inverted so a stale word never passes for a fresh one
    assign wr_data   = wr_valid ? word : ~word;
    assign frame_end = (cnt_q == 5'hd);
    assign accept    = frame_end ? acc : ~acc;
    assign target    = tgt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h0;
        end else if (cnt_q != 5'h0) begin
            cnt_q <= (cnt_q == 5'hd) ? 5'h0 : cnt_q + 5'h1;
        end else if (start) begin
            cnt_q <= 5'h1;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench of the message ram host staging buffers
`timescale 1ns/1ps
`default_nettype none
`include "mrhs_params.svh"
module tb;
    // ********************
    // signals and instances
    // ********************
    logic         pclk    = 1'b0;
    logic         presetn = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [7:0]   paddr   = 8'h00;
    logic [31:0]  pwdata  = 32'h0;
    logic         sa      = 1'b0;
    logic [3:0]   rdi     = 4'h0;
    logic [31:0]  prdata, rd, cha_wr_data, chb_wr_data, chb_rd;
    logic [127:0] txf;
    logic [6:0]   cha_target, chb_target;
    logic [3:0]   cha_wr_idx, chb_wr_idx;
    logic         pready, pslverr, err, cha_busy, chb_busy, cha_wr_valid, chb_wr_valid;
    logic         cha_frame_end, chb_frame_end, cha_accept, chb_accept;
    int           mismatches = 0;
    int           cmp_count  = 0;
    int           cyc        = 0;
    always #4 pclk = ~pclk;
    mrhs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .transmit_pending_flag(txf), .cha_wr_valid, .cha_wr_idx,
        .cha_wr_data, .cha_frame_end, .cha_accept, .cha_target, .cha_rd_idx(4'h0),
        .cha_rd_data(), .cha_busy, .chb_wr_valid, .chb_wr_idx, .chb_wr_data, .chb_frame_end,
        .chb_accept, .chb_target, .chb_rd_idx(rdi), .chb_rd_data(chb_rd), .chb_busy);
    mrhs_chan_model ma (.pclk, .presetn, .start(sa), .acc(1'b1), .tgt(7'h09),
        .wr_valid(cha_wr_valid), .wr_idx(cha_wr_idx), .wr_data(cha_wr_data),
        .frame_end(cha_frame_end), .accept(cha_accept), .target(cha_target));
    mrhs_chan_model mb (.pclk, .presetn, .start(sa), .acc(1'b0), .tgt(7'h0a),
        .wr_valid(chb_wr_valid), .wr_idx(chb_wr_idx), .wr_data(chb_wr_data),
        .frame_end(chb_frame_end), .accept(chb_accept), .target(chb_target));
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        for (int n = 0; n < 60; n++) begin
            apb(1'b0, a, 32'h0);
            if (rd[b] === 1'b0) break;
        end
        chk("flag clear", {31'h0, rd[b]}, 32'h0);
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_write();
        for (int i = 0; i < 8; i++) apb(1'b1, 8'h40 + 8'(4 * i), 32'hd0 + 32'(i));
        for (int i = 0; i < 3; i++) apb(1'b1, 8'h20 + 8'(4 * i), 32'ha0 + 32'(i));
        apb(1'b1, `MRHS_WCM_OFS, 32'h7);
        apb(1'b1, `MRHS_WRC_OFS, 32'h5);
        apb(1'b1, `MRHS_WCM_OFS, 32'h0);
        apb(1'b1, `MRHS_WRC_OFS, 32'h5);
        apb(1'b1, 8'h20, 32'hee);
        rc("wrc", `MRHS_WRC_OFS, 32'h807f_8000, 32'h8005_8000);
        poll(`MRHS_WRC_OFS, 15);
        chk("txf set", {31'h0, txf[5]}, 32'h1);
        rc("wcm", `MRHS_WCM_OFS, 32'h0007_0000, 32'h0);
        poll(`MRHS_WRC_OFS, 31);
        chk("txf clr", {31'h0, txf[5]}, 32'h0);
        rc("err", `MRHS_ERR_OFS, 32'h1, 32'h1);
        apb(1'b1, `MRHS_ERR_OFS, 32'h1);
        rc("err clr", `MRHS_ERR_OFS, 32'h1, 32'h0);
        $display("test write done");
    endtask
    task automatic t_read();
        apb(1'b1, `MRHS_RCM_OFS, 32'h3);
        apb(1'b1, `MRHS_RRC_OFS, 32'h205);
        rc("rbusy", `MRHS_RRC_OFS, 32'h8000, 32'h8000);
        poll(`MRHS_RRC_OFS, 15);
        apb(1'b1, `MRHS_RRC_OFS, 32'h100);
        rc("rrc", `MRHS_RRC_OFS, 32'h007f_0000, 32'h0005_0000);
        rc("rcm", `MRHS_RCM_OFS, 32'h0003_0000, 32'h0003_0000);
        rc("hdr", 8'h30, 32'hffff_ffff, 32'ha0);
        for (int i = 0; i < 8; i++) rc("dat", 8'h60 + 8'(4 * i), '1, 32'hd0 + 32'(i));
        apb(1'b1, `MRHS_FCFG_OFS, 32'h8504);
        for (int n = 0; n < 2; n++) begin
            apb(1'b1, `MRHS_RRC_OFS, 32'h204);
            poll(`MRHS_RRC_OFS, 15);
        end
        apb(1'b1, `MRHS_RRC_OFS, 32'h100);
        rc("fifo hdr", 8'h30, '1, 32'ha0);
        $display("test read done");
    endtask
    task automatic t_chan();
        sa <= 1'b1;
        @(posedge pclk);
        sa <= 1'b0;
        repeat (16) @(posedge pclk);
        for (int n = 0; n < 100 && cha_busy !== 1'b0; n++) @(posedge pclk);
        chk("cha_busy", {31'h0, cha_busy}, 32'h0);
        chk("chb_busy", {31'h0, chb_busy}, 32'h0);
        rdi <= 4'h2;
        repeat (2) @(posedge pclk);
        chk("chb rd", chb_rd, 32'hc000_00a2);
        apb(1'b1, `MRHS_RRC_OFS, 32'h209);
        poll(`MRHS_RRC_OFS, 15);
        apb(1'b1, `MRHS_RRC_OFS, 32'h100);
        rc("chan dat", 8'h60, '1, 32'hc000_0094);
        $display("test chan done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_write();
        t_read();
        t_chan();
        apb(1'b0, 8'hfc, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        chk("unmapped", rd, 32'h0);
        $display("test map done");
        print_verdict();
    end
endmodule
`default_nettype wire
